// ### core/afcc_top.sv
// front-end control and output code formatting for a 20-bit sigma-delta converter
// assumes modulator results arrive on CLK and the reference-absent flag is asynchronous
//
// What this block does
// [RQ1] buffer bit set routes input through buffer, clear routes it straight to modulator
// [RQ2] unbuffered path only at gain 1 or 2; higher gains force buffer on
// [RQ3] gain 1 or 2 applied digitally; gain 4 and up enables in-amp
// [RQ4] eight gain settings 1 to 128 from three-bit gain field
// [RQ5] gain field is a binary exponent: 0 gives 1, 7 gives 128
// [RQ6] polarity bit chooses unipolar or bipolar coding
// [RQ7] unipolar coding is straight binary 00000 to fffff
// [RQ8] bipolar coding is offset binary, zero input gives 80000
// [RQ9] 20-bit codes; bipolar spans half scale offset by one
// [RQ10] missing reference clamps output data to all ones
// [RQ11] burnout pair only on input channels one and two, on selected pair
// [RQ12] one bit switches both burnout currents; zero turns them off
// [RQ13] excitation bits enable two sources, steer them, pick 10/210/1000 uA
// [RQ14] bias select and boost control half-supply bias on selected negative input
// [RQ15] boost set runs bias generator at high current, clear at low
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns

module afcc_top
  import afcc_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic      [31:0]         HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  input  wire logic                RAW_VALID,
  input  wire logic [RAW_W-1:0]    RAW_DATA,
  input  wire logic                REF_ABSENT,
  output logic                     BUFFER_PATH_EN,
  output logic                     INAMP_EN,
  output logic      [GAIN_W-1:0]   INAMP_GAIN,
  output logic      [CHAN_W-1:0]   CHANNEL_SEL,
  output logic                     BURNOUT_CURRENT_ENABLE,
  output logic      [1:0]          EXCITATION_OUTPUT_A,
  output logic      [1:0]          EXCITATION_OUTPUT_B,
  output logic      [1:0]          EXCITATION_LEVEL,
  output logic      [BIAS_W-1:0]   BIAS_SELECT,
  output logic                     BIAS_BOOST,
  output logic      [CODE_W-1:0]   CODE_OUT,
  output logic                     CODE_VALID
);

  // ************************************************************
  // functions
  // ************************************************************
  // saturate a signed extended value into the 20-bit code range
  function automatic logic [CODE_W-1:0] sat_code(input logic signed [EXT_W-1:0] v);
    logic [CODE_W-1:0] r;
    if (v < 0) begin
      r = '0;
    end else if (v > $signed(CODE_MAX)) begin
      r = CODE_ONES;
    end else begin
      r = v[CODE_W-1:0];
    end
    return r;
  endfunction

  function automatic logic is_dgain(input logic [GAIN_W-1:0] g);
    return (g == GAIN_X1) || (g == GAIN_X2);
  endfunction

  // ************************************************************
  // register state
  // ************************************************************
  logic [CFG_W-1:0]   cfg_ff,   nxt_cfg;
  logic [EXC_W-1:0]   exc_ff,   nxt_exc;
  logic [CODE_W-1:0]  code_ff,  nxt_code;
  logic               rdy_ff,   nxt_rdy;
  logic               cval_ff,  nxt_cval;
  logic               wr_ff,    nxt_wr;
  logic [ADDR_W-1:0]  waddr_ff, nxt_waddr;
  logic [31:0]        rdata_ff, nxt_rdata;
  logic               ref_s1_ff;
  logic               ref_s2_ff;

  // control outputs
  logic               buf_ff,   nxt_buf;
  logic               inamp_ff, nxt_inamp;
  logic [GAIN_W-1:0]  gain_ff,  nxt_gain;
  logic [CHAN_W-1:0]  chan_ff,  nxt_chan;
  logic               bo_ff,    nxt_bo;
  logic [1:0]         exa_ff,   nxt_exa;
  logic [1:0]         exb_ff,   nxt_exb;
  logic [1:0]         exl_ff,   nxt_exl;
  logic [BIAS_W-1:0]  bias_ff,  nxt_bias;
  logic               boost_ff, nxt_boost;

  logic               addr_ok;
  logic [ADDR_W-1:0]  haddr_lo;
  logic [GAIN_W-1:0]  gcode;
  logic [1:0]         dir;
  logic               src_on;
  logic signed [EXT_W-1:0] raw_ext;
  logic signed [EXT_W-1:0] scaled;
  logic signed [EXT_W-1:0] bip;
  logic [CODE_W-1:0]  fmt;

  // ************************************************************
  // reference-absent synchroniser
  // ************************************************************
  // the flag may change at any time; only the second stage feeds logic
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
    end else begin
      ref_s1_ff <= REF_ABSENT;
      ref_s2_ff <= ref_s1_ff;
    end
  end

  // ************************************************************
  // bus slave and register file
  // ************************************************************
  assign haddr_lo = HADDR[ADDR_W-1:0];
  assign addr_ok  = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_exc   = exc_ff;
    nxt_wr    = addr_ok && HWRITE;
    nxt_waddr = addr_ok ? haddr_lo : waddr_ff;
    // the write lands in its data phase
    if (wr_ff && (waddr_ff == CFG_OFS)) begin
      nxt_cfg = HWDATA[CFG_W-1:0];
    end
    if (wr_ff && (waddr_ff == EXC_OFS)) begin
      nxt_exc = HWDATA[EXC_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cfg_ff   <= CFG_RST;
      exc_ff   <= EXC_RST;
      wr_ff    <= 1'b0;
      waddr_ff <= '0;
    end else begin
      cfg_ff   <= nxt_cfg;
      exc_ff   <= nxt_exc;
      wr_ff    <= nxt_wr;
      waddr_ff <= nxt_waddr;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // configuration and excitation reads taken from next values so a write just before is seen
  // unmapped offsets and write cycles read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (addr_ok && !HWRITE) begin
      unique case (haddr_lo)
        CFG_OFS:  nxt_rdata[CFG_W-1:0] = nxt_cfg;
        EXC_OFS:  nxt_rdata[EXC_W-1:0] = nxt_exc;
        DATA_OFS: nxt_rdata[CODE_W-1:0] = code_ff;
        STAT_OFS: begin
          nxt_rdata[ST_READY_BIT] = rdy_ff;
          nxt_rdata[ST_NOREF_BIT] = ref_s2_ff;
        end
        default:  nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // stands for the data phase only, zero after it
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ************************************************************
  // output coding
  // ************************************************************
  always_comb begin
    gcode   = cfg_ff[GAIN_LSB +: GAIN_W];
    raw_ext = {{(EXT_W-RAW_W){RAW_DATA[RAW_W-1]}}, RAW_DATA};
    // digital gain of two; in-amp gains arrive already amplified
    scaled  = (gcode == GAIN_X2) ? (raw_ext <<< 1) : raw_ext; // RQ3
    bip     = (scaled >>> 1) + $signed(CODE_MID); // RQ9
    if (cfg_ff[UNIPOLAR_BIT]) begin // RQ6
      fmt = sat_code(scaled); // RQ7
    end else begin
      fmt = sat_code(bip); // RQ8
    end
    if (ref_s2_ff) begin
      fmt = CODE_ONES; // RQ10
    end
    nxt_code = RAW_VALID ? fmt : code_ff;
    nxt_cval = RAW_VALID;
  end

  // the code holds between results so software may read it again
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      code_ff <= '0;
      cval_ff <= 1'b0;
    end else begin
      code_ff <= nxt_code;
      cval_ff <= nxt_cval;
    end
  end

  // ************************************************************
  // result-ready flag
  // ************************************************************
  always_comb begin
    // a new result wins over a data read in the same cycle
    nxt_rdy  = rdy_ff;
    if (addr_ok && !HWRITE && (haddr_lo == DATA_OFS)) begin
      nxt_rdy = 1'b0;
    end
    if (RAW_VALID) begin
      nxt_rdy = 1'b1;
    end
  end

  // cleared by a data read so software can tell a fresh result from a stale one
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdy_ff <= 1'b0;
    end else begin
      rdy_ff <= nxt_rdy;
    end
  end

  // ************************************************************
  // analog front-end controls
  // ************************************************************
  always_comb begin
    nxt_gain  = nxt_cfg[GAIN_LSB +: GAIN_W]; // RQ4 RQ5
    nxt_buf   = nxt_cfg[BUF_EN_BIT] || !is_dgain(nxt_gain); // RQ1 RQ2
    nxt_inamp = !is_dgain(nxt_gain); // RQ3
    nxt_chan  = nxt_cfg[CHAN_LSB +: CHAN_W];
    // burnout pair exists only on channels one and two
    nxt_bo    = nxt_cfg[BURNOUT_BIT] && (nxt_chan <= CHAN_TWO); // RQ11 RQ12
    nxt_bias  = nxt_cfg[BIAS_LSB +: BIAS_W]; // RQ14
    // boost is held off while the generator is off, so it never draws current alone
    nxt_boost = (nxt_bias != BIAS_OFF) && nxt_cfg[BOOST_BIT]; // RQ15
    dir       = nxt_exc[EXC_DIR_LSB +: 2];
    nxt_exl   = nxt_exc[EXC_LVL_LSB +: 2];
    src_on    = (nxt_exl != LVL_OFF);
    // bit 0 is source one, bit 1 is source two
    unique case (dir) // RQ13
      DIR_STRAIGHT: begin
        nxt_exa = {1'b0, src_on};
        nxt_exb = {src_on, 1'b0};
      end
      DIR_SWAPPED: begin
        nxt_exa = {src_on, 1'b0};
        nxt_exb = {1'b0, src_on};
      end
      DIR_BOTH_A: begin
        nxt_exa = {src_on, src_on};
        nxt_exb = 2'h0;
      end
      DIR_BOTH_B: begin
        nxt_exa = 2'h0;
        nxt_exb = {src_on, src_on};
      end
    endcase
  end

  // ************************************************************
  // front-end control registers
  // ************************************************************
  // all controls move on the edge that stores the configuration or excitation register they come from
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      buf_ff   <= 1'b0;
      inamp_ff <= 1'b0;
      gain_ff  <= '0;
      chan_ff  <= '0;
      bo_ff    <= 1'b0;
      exa_ff   <= 2'h0;
      exb_ff   <= 2'h0;
      exl_ff   <= 2'h0;
      bias_ff  <= '0;
      boost_ff <= 1'b0;
    end else begin
      buf_ff   <= nxt_buf;
      inamp_ff <= nxt_inamp;
      gain_ff  <= nxt_gain;
      chan_ff  <= nxt_chan;
      bo_ff    <= nxt_bo;
      exa_ff   <= nxt_exa;
      exb_ff   <= nxt_exb;
      exl_ff   <= nxt_exl;
      bias_ff  <= nxt_bias;
      boost_ff <= nxt_boost;
    end
  end

  // ************************************************************
  // bus response
  // ************************************************************
  // zero-wait-state slave, always OKAY
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // ************************************************************
  // outputs, each straight from a register
  // ************************************************************
  assign HRDATA                 = rdata_ff;
  assign BUFFER_PATH_EN         = buf_ff;
  assign INAMP_EN               = inamp_ff;
  assign INAMP_GAIN             = gain_ff;
  assign CHANNEL_SEL            = chan_ff;
  assign BURNOUT_CURRENT_ENABLE = bo_ff;
  assign EXCITATION_OUTPUT_A    = exa_ff;
  assign EXCITATION_OUTPUT_B    = exb_ff;
  assign EXCITATION_LEVEL       = exl_ff;
  assign BIAS_SELECT            = bias_ff;
  assign BIAS_BOOST             = boost_ff;
  assign CODE_OUT               = code_ff;
  assign CODE_VALID             = cval_ff;

endmodule

// ### core/afcc_pkg.sv
// constants shared by the front-end control and output-coding block
// assumes a single 20 MHz clock domain and an AHB-Lite register bus
package afcc_pkg;
  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [7:0]  CFG_OFS       = 8'h00;
  localparam logic [7:0]  EXC_OFS       = 8'h04;
  localparam logic [7:0]  DATA_OFS      = 8'h08;
  localparam logic [7:0]  STAT_OFS      = 8'h0c;
  localparam int          ADDR_W        = 8;

  // ************************************************************
  // configuration register fields
  // ************************************************************
  localparam int          CFG_W         = 11;
  localparam int          GAIN_LSB      = 0;
  localparam int          GAIN_W        = 3;
  localparam int          UNIPOLAR_BIT  = 3;
  localparam int          BUF_EN_BIT    = 4;
  localparam int          BURNOUT_BIT   = 5;
  localparam int          BIAS_LSB      = 6;
  localparam int          BIAS_W        = 2;
  localparam int          BOOST_BIT     = 8;
  localparam int          CHAN_LSB      = 9;
  localparam int          CHAN_W        = 2;
  localparam logic [CFG_W-1:0] CFG_RST  = 11'h000;

  // ************************************************************
  // excitation register fields
  // ************************************************************
  localparam int          EXC_W         = 4;
  localparam int          EXC_DIR_LSB   = 0;
  localparam int          EXC_LVL_LSB   = 2;
  localparam logic [EXC_W-1:0] EXC_RST  = 4'h0;
  localparam logic [1:0]  DIR_STRAIGHT  = 2'h0;
  localparam logic [1:0]  DIR_SWAPPED   = 2'h1;
  localparam logic [1:0]  DIR_BOTH_A    = 2'h2;
  localparam logic [1:0]  DIR_BOTH_B    = 2'h3;
  localparam logic [1:0]  LVL_OFF       = 2'h0;

  // ************************************************************
  // gain codes, channels, coding
  // ************************************************************
  localparam logic [GAIN_W-1:0] GAIN_X1 = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_X2 = 3'h1;
  localparam logic [CHAN_W-1:0] CHAN_TWO = 2'h1;
  localparam logic [BIAS_W-1:0] BIAS_OFF = 2'h0;
  localparam int          CODE_W        = 20;
  localparam int          RAW_W         = 21;
  localparam int          EXT_W         = 23;
  localparam logic [EXT_W-1:0] CODE_MAX = 23'h0fffff;
  localparam logic [EXT_W-1:0] CODE_MID = 23'h080000;
  localparam logic [CODE_W-1:0] CODE_ONES = 20'hfffff;

  // ************************************************************
  // status register bits
  // ************************************************************
  localparam int          ST_READY_BIT  = 0;
  localparam int          ST_NOREF_BIT  = 1;

  // ************************************************************
  // bus encodings
  // ************************************************************
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

// ### test/afcc_checker.sv
// assertions on the front-end control block, bound onto its top module
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
module afcc_checker
  import afcc_pkg::*;
(
  input wire logic              CLK,
  input wire logic              SYS_RST,
  input wire logic              RAW_VALID,
  input wire logic              REF_ABSENT,
  input wire logic              BUFFER_PATH_EN,
  input wire logic              INAMP_EN,
  input wire logic [GAIN_W-1:0] INAMP_GAIN,
  input wire logic [CHAN_W-1:0] CHANNEL_SEL,
  input wire logic              BURNOUT_CURRENT_ENABLE,
  input wire logic [BIAS_W-1:0] BIAS_SELECT,
  input wire logic              BIAS_BOOST,
  input wire logic [CODE_W-1:0] CODE_OUT,
  input wire logic              CODE_VALID
);
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_buf_forced: assert property (INAMP_GAIN >= 3'h2 |-> BUFFER_PATH_EN)
    else $error("buffer path off at high gain");
  a_inamp_tied: assert property (INAMP_EN == (INAMP_GAIN >= 3'h2))
    else $error("in-amp enable disagrees with gain");
  a_result_next: assert property (RAW_VALID |=> CODE_VALID)
    else $error("no code one cycle after raw sample");
  a_valid_cause: assert property (CODE_VALID |-> $past(RAW_VALID))
    else $error("code valid without raw sample");
  a_code_hold: assert property (!RAW_VALID |=> $stable(CODE_OUT))
    else $error("code changed without raw sample");
  a_ref_clamp: assert property ((!SYS_RST && REF_ABSENT)[*3] ##0 RAW_VALID
    |=> CODE_OUT == 20'hfffff) else $error("code not clamped without reference");
  a_burnout_chan: assert property (BURNOUT_CURRENT_ENABLE |-> CHANNEL_SEL <= 2'h1)
    else $error("burnout current on a channel without it");
  a_boost_gated: assert property (BIAS_SELECT == 2'h0 |-> !BIAS_BOOST)
    else $error("boost active with bias generator off");
  c_result: cover property (RAW_VALID ##1 CODE_VALID);
  c_unbuffered: cover property (!BUFFER_PATH_EN && INAMP_GAIN == 3'h1);
  c_boost: cover property (BIAS_BOOST);
endmodule

bind afcc_top afcc_checker afcc_checker_inst (.CLK(CLK), .SYS_RST(SYS_RST),
  .RAW_VALID(RAW_VALID), .REF_ABSENT(REF_ABSENT), .BUFFER_PATH_EN(BUFFER_PATH_EN),
  .INAMP_EN(INAMP_EN), .INAMP_GAIN(INAMP_GAIN), .CHANNEL_SEL(CHANNEL_SEL),
  .BURNOUT_CURRENT_ENABLE(BURNOUT_CURRENT_ENABLE), .BIAS_SELECT(BIAS_SELECT),
  .BIAS_BOOST(BIAS_BOOST), .CODE_OUT(CODE_OUT), .CODE_VALID(CODE_VALID));

// ### test/afcc_sensor_model.sv
// sensor and modulator side: delivers raw samples and the reference-absent level
// assumes the caller enters send between clock edges or at one
`timescale 1ns/1ns
module afcc_sensor_model
(
  input  wire logic        clk,
  input  wire logic        ref_missing,
  output logic             raw_valid,
  output logic [20:0]      raw_data,
  output logic             ref_absent
);
  initial begin
    raw_valid = 1'b0;
    raw_data  = 21'h0;
  end
  assign ref_absent = ref_missing;
  // outside a sample the data shows the inverse, so a stale value never passes
  task automatic send(input logic [20:0] v);
    @(posedge clk);
    raw_valid <= 1'b1;
    raw_data  <= v;
    @(posedge clk);
    raw_valid <= 1'b0;
    raw_data  <= ~v;
  endtask
endmodule

// ### test/tb.sv
// self-checking bench for the front-end control and output coding block
// assumes the design answers every bus cycle through its own ready output
`timescale 1ns/1ns
module tb;
  import afcc_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        ref_missing = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r;
  logic [20:0] raw_data, smp;
  logic [19:0] code_out, e;
  logic [10:0] c;
  logic [2:0]  gain;
  logic [1:0]  chan, bsel, ea, eb, elvl;
  logic        hreadyout, hresp, raw_valid, ref_absent, buf_en, amp_en, bo, boost, cv, hi;
  // excitation routing {A, B} per direction code: bit 0 source one, bit 1 source two
  logic [3:0]  route [4] = '{4'h6, 4'h9, 4'hc, 4'h3};
  logic [20:0] edges [5] = '{21'h0, 21'h0fffff, 21'h100000, 21'h1fffff, 21'h07ffff};
  logic [19:0] exp_q [$];
  int          bad_count, checks_done, cycles;
  always #25 clk = ~clk;
  afcc_top afcc_top_inst (.CLK(clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RAW_VALID(raw_valid),
    .RAW_DATA(raw_data), .REF_ABSENT(ref_absent), .BUFFER_PATH_EN(buf_en), .INAMP_EN(amp_en),
    .INAMP_GAIN(gain), .CHANNEL_SEL(chan), .BURNOUT_CURRENT_ENABLE(bo),
    .EXCITATION_OUTPUT_A(ea), .EXCITATION_OUTPUT_B(eb), .EXCITATION_LEVEL(elvl),
    .BIAS_SELECT(bsel), .BIAS_BOOST(boost), .CODE_OUT(code_out), .CODE_VALID(cv));
  afcc_sensor_model afcc_sensor_model_inst (.clk(clk), .ref_missing(ref_missing),
    .raw_valid(raw_valid), .raw_data(raw_data), .ref_absent(ref_absent));
  // ************************************************************
  // checking, bus and model helpers
  // ************************************************************
  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 6000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // control outputs move on the edge that stores the write; two more edges are waited here
  task automatic wr_settle(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic logic [19:0] fmt(logic [20:0] x, int g, int uni);
    int d;
    d = int'($signed(x));
    if (g == 1) d = d * 2;
    if (uni == 0) d = (d >>> 1) + 32'sh0008_0000;
    if (d < 0) d = 0;
    if (d > 32'sh000f_ffff) d = 32'sh000f_ffff;
    return d[19:0];
  endfunction
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(22));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(CFG_OFS, 1'b0, 32'h0);
    chk(r, 32'h0);
    xfer(EXC_OFS, 1'b0, 32'h0);
    chk(r, 32'h0);
    xfer(8'h10, 1'b1, 32'hffffffff);
    xfer(8'h10, 1'b0, 32'h0);
    chk({r, hresp}, 33'h0);
    for (int i = 0; i < 32; i++) begin
      c = 11'($urandom);
      c[5:0] = {i[4], i[3], c[3], i[2:0]};
      hi = (c[2:0] >= 3'h2);
      wr_settle(CFG_OFS, {21'h0, c});
      chk({buf_en, amp_en, gain}, {c[4] | hi, hi, c[2:0]});
      chk({chan, bo}, {c[10:9], c[5] & !c[10]});
      chk({bsel, boost}, {c[7:6], c[8] & (c[7:6] != 2'h0)});
      xfer(CFG_OFS, 1'b0, 32'h0);
      chk(r, {21'h0, c});
    end
    for (int i = 0; i < 16; i++) begin
      wr_settle(EXC_OFS, 32'(i));
      chk(elvl, i[3:2]);
      chk({ea, eb}, (i[3:2] != 2'h0) ? route[i[1:0]] : 4'h0);
    end
    for (int u = 0; u < 2; u++) begin
      for (int g = 0; g < 3; g++) begin
        wr_settle(CFG_OFS, 32'(u * 8 + g));
        for (int k = 0; k < 8; k++) begin
          smp = (k < 5) ? edges[k] : 21'($urandom);
          exp_q.push_back(fmt(smp, g, u));
          afcc_sensor_model_inst.send(smp);
          #1;
          e = exp_q.pop_front();
          chk({cv, code_out}, {1'b1, e});
        end
        xfer(DATA_OFS, 1'b0, 32'h0);
        chk(r, {12'h0, e});
        xfer(STAT_OFS, 1'b0, 32'h0);
        chk(r, 32'h0);
      end
    end
    @(posedge clk);
    ref_missing <= 1'b1;
    repeat (3) @(posedge clk);
    afcc_sensor_model_inst.send(21'h0);
    #1;
    chk(code_out, 20'hfffff);
    xfer(STAT_OFS, 1'b0, 32'h0);
    chk(r, 32'h3);
    @(posedge clk);
    ref_missing <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({buf_en, amp_en, gain, bo, boost, code_out}, 32'h0);
    xfer(CFG_OFS, 1'b0, 32'h0);
    chk(r, 32'h0);
    give_verdict();
  end
endmodule
